// ### src/pig_pkg.sv
// Purpose: shared constants and types for the modulator irq and generator control
// Assumes: 32-bit register port, word offsets as byte addresses
// Notes:   single generator, 16-bit counter
package pig_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_MASTER_CONTROL   = 12'h000;
    localparam logic [11:0] OFS_MOD_IRQ_ENABLE   = 12'h014;
    localparam logic [11:0] OFS_MOD_IRQ_RAW      = 12'h018;
    localparam logic [11:0] OFS_MOD_IRQ_CLEAR    = 12'h01C;
    localparam logic [11:0] OFS_FAULT_STATUS     = 12'h020;
    localparam logic [11:0] OFS_GEN0_CONTROL     = 12'h040;
    localparam logic [11:0] OFS_GEN0_IRQ_ENABLE  = 12'h044;
    localparam logic [11:0] OFS_GEN0_IRQ_RAW     = 12'h048;
    localparam logic [11:0] OFS_GEN0_IRQ_CLEAR   = 12'h04C;
    localparam logic [11:0] OFS_GEN0_LOAD        = 12'h050;
    localparam logic [11:0] OFS_GEN0_COUNT       = 12'h054;
    localparam logic [11:0] OFS_GEN0_CMP_A       = 12'h058;
    localparam logic [11:0] OFS_GEN0_CMP_B       = 12'h05C;
    localparam logic [11:0] OFS_GEN0_PAIR_CTL    = 12'h068;
    localparam logic [11:0] OFS_GEN0_PAIR_DELAY  = 12'h06C;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_FAULT_IRQ      = 16;
    localparam int BIT_GEN0_IRQ       = 0;
    localparam int BIT_FAULT_LIVE     = 0;
    localparam int BIT_SYNC_REQUEST   = 0;
    localparam int BIT_CMP_B_UPD      = 5;
    localparam int BIT_CMP_A_UPD      = 4;
    localparam int BIT_LOAD_UPD       = 3;
    localparam int BIT_DEBUG_RUN      = 2;
    localparam int BIT_UPDOWN_MODE    = 1;
    localparam int BIT_GEN_ENABLE     = 0;
    localparam int BIT_PAIR_ENABLE    = 0;
    localparam int EV_ZERO  = 0;
    localparam int EV_LOAD  = 1;
    localparam int EV_A_UP  = 2;
    localparam int EV_A_DN  = 3;
    localparam int EV_B_UP  = 4;
    localparam int EV_B_DN  = 5;
    localparam int CNT_W    = 16;
    localparam int EV_W     = 6;
    localparam int CTL_W    = 6;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [7:0]  RST_DELAY = 8'h00;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } pig_bus_type;
    typedef enum logic [0:0] {
        DIR_DOWN = 1'b0,
        DIR_UP   = 1'b1
    } pig_dir_type;
endpackage : pig_pkg

// ### src/pig_top.sv
// Purpose: module irq summary, fault latch and generator 0 control with counter
// Assumes: mclk 20 MHz, rst_n synchronous active low, fault and debug are pins
// Notes:   outputs are flops; register read data one cycle after read strobe
//
// What this block does
// R01 - Fault enable routes fault to module interrupt
// R02 - Generator enable routes generator irq to interrupt
// R03 - Raw status shows sources regardless of module enables
// R04 - Fault irq latched until software clears it
// R05 - Generator summary bit follows generator, unlatched
// R06 - Write one clears fault latch; zero ignored
// R07 - Clear register bit 0 read-only generator flag
// R08 - Status bit 0 shows live fault input
// R09 - Two outputs: independent or complementary delayed pair
// R10 - Comparator A update at zero, or after request
// R11 - Comparator B update timing same as A
// R12 - Load update at zero, or after request
// R13 - Debug halts counter at zero unless run bit
// R14 - Down mode counts load to zero, wraps
// R15 - Up/down mode counts zero to load and back
// R16 - Enable clear stops generator entirely
// R17 - Software leaves reserved bits alone
// R18 - Sync request applies updates at zero, self-clears
// R19 - Generator status write-one clears reason
// R20 - Interrupt is OR of raw AND enable
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pig_top (
    input  wire logic                mclk,
    input  wire logic                rst_n,
    input  wire pig_pkg::pig_bus_type bus,
    output var  logic [31:0]         rdata,
    input  wire logic                fault_pin,
    input  wire logic                debug_pin,
    output var  logic                gen_output_first,
    output var  logic                gen_output_second,
    output var  logic                module_irq
);
    import pig_pkg::*;
    // ------------------------------------------------------------
    // pin synchronisers: [0] fault, [1] debug
    // ------------------------------------------------------------
    logic [1:0] s1_reg, s2_reg, s3_reg, pin_reg;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s1_reg  <= 2'h0;
            s2_reg  <= 2'h0;
            s3_reg  <= 2'h0;
            pin_reg <= 2'h0;
        end else begin
            s1_reg  <= {debug_pin, fault_pin};
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            pin_reg <= (s2_reg & s3_reg) | (pin_reg & (s2_reg | s3_reg));
        end
    end
    logic fault_live, debug_live;
    assign fault_live = pin_reg[0];
    assign debug_live = pin_reg[1];
    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    logic wr_en;
    logic [31:0] wd;
    assign wr_en = bus.wr;
    assign wd    = bus.wdata;
    logic             fault_en_reg, gen_en_reg, sync_req_reg, pair_en_reg;
    logic [CTL_W-1:0] ctl_reg;
    logic [EV_W-1:0]  gen_inten_reg, gen_ris_reg;
    logic [CNT_W-1:0] load_new_reg, cmpa_new_reg, cmpb_new_reg;
    logic [CNT_W-1:0] load_act_reg, cmpa_act_reg, cmpb_act_reg, cnt_reg;
    logic [7:0]       delay_reg;
    logic             load_dirty_reg, cmpa_dirty_reg, cmpb_dirty_reg;
    logic             fault_lat_reg;
    pig_dir_type      dir_reg;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fault_en_reg  <= 1'b0;
            gen_en_reg    <= 1'b0;
            ctl_reg       <= RST_WORD[CTL_W-1:0];
            gen_inten_reg <= RST_WORD[EV_W-1:0];
            pair_en_reg   <= 1'b0;
            delay_reg     <= RST_DELAY;
        end else if (wr_en) begin
            case (bus.addr)
                OFS_MOD_IRQ_ENABLE: begin
                    fault_en_reg <= wd[BIT_FAULT_IRQ];
                    gen_en_reg   <= wd[BIT_GEN0_IRQ];
                end
                OFS_GEN0_CONTROL:    ctl_reg       <= wd[CTL_W-1:0];
                OFS_GEN0_IRQ_ENABLE: gen_inten_reg <= wd[EV_W-1:0];
                OFS_GEN0_PAIR_CTL:   pair_en_reg   <= wd[BIT_PAIR_ENABLE];
                OFS_GEN0_PAIR_DELAY: delay_reg     <= wd[7:0];
                default: ;
            endcase
        end
    end
    logic enable, updown, debug_run;
    assign enable    = ctl_reg[BIT_GEN_ENABLE];
    assign updown    = ctl_reg[BIT_UPDOWN_MODE];
    assign debug_run = ctl_reg[BIT_DEBUG_RUN];
    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    logic zero_evt, halt;
    assign zero_evt = enable && (cnt_reg == RST_COUNT);
    assign halt     = zero_evt && debug_live && !debug_run;            // [R13]

    always_ff @(posedge mclk) begin
        if (!rst_n || !enable) begin                                   // [R16]
            cnt_reg <= RST_COUNT;
            dir_reg <= DIR_UP;
        end else if (halt) begin                                       // [R13]
            cnt_reg <= cnt_reg;
        end else if (!updown) begin                                    // [R14]
            dir_reg <= DIR_DOWN;
            if (cnt_reg == RST_COUNT)
                cnt_reg <= load_act_reg;
            else
                cnt_reg <= cnt_reg - 16'h0001;
        end else if (load_act_reg == RST_COUNT) begin                  // [R15]
            cnt_reg <= RST_COUNT;
            dir_reg <= DIR_UP;
        end else if (dir_reg == DIR_UP) begin                          // [R15]
            if (cnt_reg >= load_act_reg) begin
                dir_reg <= DIR_DOWN;
                cnt_reg <= cnt_reg - 16'h0001;
            end else begin
                cnt_reg <= cnt_reg + 16'h0001;
            end
        end else begin                                                 // [R15]
            if (cnt_reg == RST_COUNT) begin
                dir_reg <= DIR_UP;
                cnt_reg <= cnt_reg + 16'h0001;
            end else begin
                cnt_reg <= cnt_reg - 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // shadowed load and comparator updates
    // ------------------------------------------------------------
    logic go_load, go_a, go_b;
    assign go_load = zero_evt && load_dirty_reg
                   && (!ctl_reg[BIT_LOAD_UPD] || sync_req_reg);       // [R12]
    assign go_a    = zero_evt && cmpa_dirty_reg
                   && (!ctl_reg[BIT_CMP_A_UPD] || sync_req_reg);      // [R10]
    assign go_b    = zero_evt && cmpb_dirty_reg
                   && (!ctl_reg[BIT_CMP_B_UPD] || sync_req_reg);      // [R11]

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            load_new_reg   <= RST_COUNT;
            cmpa_new_reg   <= RST_COUNT;
            cmpb_new_reg   <= RST_COUNT;
            load_act_reg   <= RST_COUNT;
            cmpa_act_reg   <= RST_COUNT;
            cmpb_act_reg   <= RST_COUNT;
            load_dirty_reg <= 1'b0;
            cmpa_dirty_reg <= 1'b0;
            cmpb_dirty_reg <= 1'b0;
        end else begin
            if (go_load) begin                                         // [R12]
                load_act_reg   <= load_new_reg;
                load_dirty_reg <= 1'b0;
            end
            if (go_a) begin                                            // [R10]
                cmpa_act_reg   <= cmpa_new_reg;
                cmpa_dirty_reg <= 1'b0;
            end
            if (go_b) begin                                            // [R11]
                cmpb_act_reg   <= cmpb_new_reg;
                cmpb_dirty_reg <= 1'b0;
            end
            // a rewrite before the update replaces the pending value
            if (wr_en && bus.addr == OFS_GEN0_LOAD) begin
                load_new_reg   <= wd[CNT_W-1:0];
                load_dirty_reg <= 1'b1;
            end
            if (wr_en && bus.addr == OFS_GEN0_CMP_A) begin
                cmpa_new_reg   <= wd[CNT_W-1:0];
                cmpa_dirty_reg <= 1'b1;
            end
            if (wr_en && bus.addr == OFS_GEN0_CMP_B) begin
                cmpb_new_reg   <= wd[CNT_W-1:0];
                cmpb_dirty_reg <= 1'b1;
            end
        end
    end

    // request stays until a zero has applied what was queued
    always_ff @(posedge mclk) begin
        if (!rst_n)
            sync_req_reg <= 1'b0;
        else if (wr_en && bus.addr == OFS_MASTER_CONTROL
                 && wd[BIT_SYNC_REQUEST])
            sync_req_reg <= 1'b1;                                      // [R18]
        else if (zero_evt)
            sync_req_reg <= 1'b0;                                      // [R18]
    end

    // ------------------------------------------------------------
    // generator interrupt reasons
    // ------------------------------------------------------------
    logic [EV_W-1:0] ev;
    logic            up_now;
    assign up_now = updown && (dir_reg == DIR_UP);
    assign ev[EV_ZERO] = zero_evt;
    assign ev[EV_LOAD] = enable && (cnt_reg == load_act_reg);
    assign ev[EV_A_UP] = enable && (cnt_reg == cmpa_act_reg) && up_now;
    assign ev[EV_A_DN] = enable && (cnt_reg == cmpa_act_reg) && !up_now;
    assign ev[EV_B_UP] = enable && (cnt_reg == cmpb_act_reg) && up_now;
    assign ev[EV_B_DN] = enable && (cnt_reg == cmpb_act_reg) && !up_now;
    logic [EV_W-1:0] gen_clr;
    assign gen_clr = (wr_en && bus.addr == OFS_GEN0_IRQ_CLEAR)
                   ? wd[EV_W-1:0] : RST_WORD[EV_W-1:0];

    always_ff @(posedge mclk) begin
        if (!rst_n)
            gen_ris_reg <= RST_WORD[EV_W-1:0];
        else
            gen_ris_reg <= ev | (gen_ris_reg & ~gen_clr);             // [R19]
    end
    logic gen_irq_now;
    assign gen_irq_now = |(gen_ris_reg & gen_inten_reg);              // [R05]

    // ------------------------------------------------------------
    // module interrupt summary
    // ------------------------------------------------------------
    logic fault_clr;
    assign fault_clr = wr_en && bus.addr == OFS_MOD_IRQ_CLEAR
                     && wd[BIT_FAULT_IRQ];                             // [R06]

    always_ff @(posedge mclk) begin
        if (!rst_n)
            fault_lat_reg <= 1'b0;
        else if (fault_live)
            fault_lat_reg <= 1'b1;                                     // [R04]
        else if (fault_clr)
            fault_lat_reg <= 1'b0;                                     // [R06]
    end
    logic [31:0] raw_word, isc_word;
    always_comb begin
        raw_word = RST_WORD;
        raw_word[BIT_FAULT_IRQ] = fault_lat_reg;                       // [R03]
        raw_word[BIT_GEN0_IRQ]  = gen_irq_now;                         // [R05]
        isc_word = RST_WORD;
        isc_word[BIT_FAULT_IRQ] = fault_lat_reg && fault_en_reg;
        isc_word[BIT_GEN0_IRQ]  = gen_irq_now && gen_en_reg;           // [R07]
    end

    always_ff @(posedge mclk) begin
        if (!rst_n)
            module_irq <= 1'b0;
        else
            module_irq <= |isc_word;                                   // [R01] [R02] [R20]
    end

    // ------------------------------------------------------------
    // output stage
    // ------------------------------------------------------------
    logic [1:0] src;
    logic [7:0] dly;
    logic       a_raw, b_raw;
    assign a_raw  = cnt_reg < cmpa_act_reg;
    assign b_raw  = cnt_reg < cmpb_act_reg;
    assign src[0] = enable && a_raw;                                   // [R09]
    assign src[1] = enable && (pair_en_reg ? !a_raw : b_raw);          // [R09]
    assign dly    = pair_en_reg ? delay_reg : RST_DELAY;
    logic [1:0] out_reg;
    logic [7:0] edge_cnt_reg [2];
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_out
            // rising edge held off by the pair delay, falling edge at once
            always_ff @(posedge mclk) begin
                if (!rst_n || !src[gi]) begin
                    out_reg[gi]      <= 1'b0;
                    edge_cnt_reg[gi] <= RST_DELAY;
                end else if (edge_cnt_reg[gi] >= dly) begin
                    out_reg[gi]      <= 1'b1;                          // [R09]
                end else begin
                    edge_cnt_reg[gi] <= edge_cnt_reg[gi] + 8'h01;
                end
            end
        end
    endgenerate
    assign gen_output_first  = out_reg[0];
    assign gen_output_second = out_reg[1];

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata <= RST_WORD;
        end else if (bus.rd) begin
            rdata <= RST_WORD;
            case (bus.addr)
                OFS_MASTER_CONTROL: rdata[BIT_SYNC_REQUEST] <= sync_req_reg;
                OFS_MOD_IRQ_ENABLE: begin
                    rdata[BIT_FAULT_IRQ] <= fault_en_reg;
                    rdata[BIT_GEN0_IRQ]  <= gen_en_reg;
                end
                OFS_MOD_IRQ_RAW:     rdata <= raw_word;                // [R03]
                OFS_MOD_IRQ_CLEAR:   rdata <= isc_word;                // [R07]
                OFS_FAULT_STATUS:    rdata[BIT_FAULT_LIVE] <= fault_live; // [R08]
                OFS_GEN0_CONTROL:    rdata[CTL_W-1:0] <= ctl_reg;
                OFS_GEN0_IRQ_ENABLE: rdata[EV_W-1:0]  <= gen_inten_reg;
                OFS_GEN0_IRQ_RAW:    rdata[EV_W-1:0]  <= gen_ris_reg;
                OFS_GEN0_IRQ_CLEAR:  rdata[EV_W-1:0]  <= gen_ris_reg & gen_inten_reg;
                OFS_GEN0_LOAD:       rdata[CNT_W-1:0] <= load_new_reg;
                OFS_GEN0_COUNT:      rdata[CNT_W-1:0] <= cnt_reg;
                OFS_GEN0_CMP_A:      rdata[CNT_W-1:0] <= cmpa_new_reg;
                OFS_GEN0_CMP_B:      rdata[CNT_W-1:0] <= cmpb_new_reg;
                OFS_GEN0_PAIR_CTL:   rdata[BIT_PAIR_ENABLE] <= pair_en_reg;
                OFS_GEN0_PAIR_DELAY: rdata[7:0] <= delay_reg;
                default:             rdata <= RST_WORD;
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_fault_seen;
        fault_live && fault_en_reg ##1 fault_en_reg;
    endsequence
    sequence s_irq_after;
        ##1 module_irq;
    endsequence
    a_fault_irq_out: assert property (s_fault_seen |-> s_irq_after)        // [R01]
        else $error("fault enabled but no module irq");
    a_gen_irq_out: assert property (gen_irq_now && gen_en_reg |=> module_irq) // [R02]
        else $error("generator irq enabled but no module irq");
    a_irq_gated: assert property (module_irq |-> $past(|isc_word))         // [R20]
        else $error("module irq without enabled source");
    a_fault_held: assert property (fault_lat_reg && !fault_clr |=> fault_lat_reg) // [R04]
        else $error("fault latch dropped without clear");
    a_fault_clear: assert property (fault_clr && !fault_live |=> !fault_lat_reg) // [R06]
        else $error("fault latch not cleared");
    a_raw_fault: assert property (fault_live |=> raw_word[BIT_FAULT_IRQ])  // [R03]
        else $error("raw fault bit missing");
    a_sync_clear: assert property (sync_req_reg && zero_evt
                                   && !(wr_en && bus.addr == OFS_MASTER_CONTROL)
                                   |=> !sync_req_reg)                      // [R18]
        else $error("sync request did not clear at zero");
    a_down_wrap: assert property (enable && !updown && !halt
                                  && cnt_reg == RST_COUNT
                                  |=> cnt_reg == $past(load_act_reg))      // [R14]
        else $error("down count did not wrap to load");
    a_disabled_idle: assert property (!enable |=> cnt_reg == RST_COUNT
                                      && !gen_output_first && !gen_output_second) // [R16]
        else $error("disabled generator still active");
    a_debug_halt: assert property (halt |=> cnt_reg == RST_COUNT)          // [R13]
        else $error("counter moved during debug halt");
    a_load_hold: assert property (load_dirty_reg && ctl_reg[BIT_LOAD_UPD]
                                  && !sync_req_reg && !wr_en
                                  |=> $stable(load_act_reg))               // [R12]
        else $error("load applied without sync request");
    a_status_live: assert property (bus.rd && bus.addr == OFS_FAULT_STATUS
                                    |=> rdata[BIT_FAULT_LIVE] == $past(fault_live)) // [R08]
        else $error("status read differs from live fault");
endmodule : pig_top
`default_nettype wire

// ### tb/pig_far_side.sv
// Purpose: far-side model, external fault source and debug pod
// Assumes: bench commands the levels, one mclk domain
// Notes:   pins change only just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module pig_far_side (
    input  wire logic mclk,
    input  wire logic fault_cmd,
    input  wire logic debug_cmd,
    output var  logic fault_pin,
    output var  logic debug_pin
);
    // ----------------------------------------
    // fault and debug levels
    // ----------------------------------------
    initial begin
        fault_pin = 1'b0;
        debug_pin = 1'b0;
    end
    always @(posedge mclk) begin
        fault_pin <= fault_cmd;
        debug_pin <= debug_cmd;
    end
endmodule : pig_far_side
`default_nettype wire

// ### tb/pwm_irq_and_gen_control_tb.sv
// Purpose: self-checking bench for irq summary and generator control
// Assumes: 50 ns mclk, read data one cycle after read strobe
// Notes:   expected values are fixed constants, except random enable readbacks and output high times from the bench model m_hi
`timescale 1ns/1ps
`default_nettype none
module pwm_irq_and_gen_control_tb;
    import pig_pkg::*;
    logic              mclk, rst_n, fault_cmd, debug_cmd, fault_pin, debug_pin;
    logic              gen_output_first, gen_output_second, module_irq, big;
    pig_bus_type       bus;
    logic [31:0]       rdata, rv, rv2;
    int                num_errors, total_checks, exp_en, i, m_ld, m_dl, hi_q[$];
    logic [11:0]       ofs [5] = '{OFS_MOD_IRQ_ENABLE, OFS_MOD_IRQ_RAW, OFS_MOD_IRQ_CLEAR,
                                   OFS_FAULT_STATUS, OFS_GEN0_CONTROL};
    // ----------------------------------------
    // clock, design and far side
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    pig_top pig_top_inst (.mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
        .fault_pin(fault_pin), .debug_pin(debug_pin), .gen_output_first(gen_output_first),
        .gen_output_second(gen_output_second), .module_irq(module_irq));
    pig_far_side pig_far_side_inst (.mclk(mclk), .fault_cmd(fault_cmd), .debug_cmd(debug_cmd),
        .fault_pin(fault_pin), .debug_pin(debug_pin));
    // ----------------------------------------
    // bus cycles and compare
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        rd(a, rv);
        check(rv, exp);
    endtask : rchk
    // high cycles of both outputs over 32 cycles, after settling
    task automatic hi_count;
        int c1, c2;
        c1 = 0;
        c2 = 0;
        repeat (16) @(posedge mclk);
        repeat (32) begin
            @(negedge mclk);
            c1 += gen_output_first;
            c2 += gen_output_second;
        end
        hi_q.push_back(c1);
        hi_q.push_back(c2);
    endtask : hi_count
    // model: high cycles in four periods of a run, rising edge delayed
    function automatic int m_hi(input int run);
        return (run > m_dl) ? 4 * (run - m_dl) : 0;
    endfunction : m_hi
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    // ----------------------------------------
    // watchdog
    // ----------------------------------------
    initial begin
        repeat (5000) @(posedge mclk);
        num_errors++;
        wrap_up();
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        bus = '0;
        rst_n = 1'b0;
        fault_cmd = 1'b0;
        debug_cmd = 1'b0;
        num_errors = 0;
        total_checks = 0;
        void'($urandom(10655));
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        foreach (ofs[k]) rchk(ofs[k], RST_WORD);
        rchk(12'h0FC, 32'h0000_0000);
        for (i = 0; i < 4; i++) begin
            exp_en = $urandom & 32'h0001_0001;
            wr(OFS_MOD_IRQ_ENABLE, exp_en);
            rchk(OFS_MOD_IRQ_ENABLE, exp_en);
        end
        // fault seen while masked, clear refused while live
        wr(OFS_MOD_IRQ_ENABLE, 32'h0000_0000);
        fault_cmd <= 1'b1;
        repeat (8) @(posedge mclk);
        rchk(OFS_FAULT_STATUS, 32'h0000_0001);
        rchk(OFS_MOD_IRQ_RAW, 32'h0001_0000);
        check(module_irq, 32'h0);
        wr(OFS_MOD_IRQ_CLEAR, 32'h0001_0000);
        rchk(OFS_MOD_IRQ_RAW, 32'h0001_0000);
        wr(OFS_MOD_IRQ_ENABLE, 32'h0001_0000);
        repeat (3) @(posedge mclk);
        check(module_irq, 32'h1);
        rchk(OFS_MOD_IRQ_CLEAR, 32'h0001_0000);
        fault_cmd <= 1'b0;
        repeat (8) @(posedge mclk);
        rchk(OFS_FAULT_STATUS, 32'h0000_0000);
        rchk(OFS_MOD_IRQ_RAW, 32'h0001_0000);
        wr(OFS_MOD_IRQ_CLEAR, 32'h0000_FFFF);
        rchk(OFS_MOD_IRQ_RAW, 32'h0001_0000);
        wr(OFS_MOD_IRQ_CLEAR, 32'h0001_0000);
        rchk(OFS_MOD_IRQ_RAW, 32'h0000_0000);
        check(module_irq, 32'h0);
        // generator summary, counting modes
        wr(OFS_GEN0_LOAD, 32'h0000_0003);
        wr(OFS_GEN0_IRQ_ENABLE, 32'h0000_0001);
        wr(OFS_MOD_IRQ_ENABLE, 32'h0000_0001);
        wr(OFS_GEN0_CONTROL, 32'h0000_0001);
        repeat (10) @(posedge mclk);
        rchk(OFS_MOD_IRQ_RAW, 32'h0000_0001);
        rchk(OFS_MOD_IRQ_CLEAR, 32'h0000_0001);
        check(module_irq, 32'h1);
        for (i = 0; i < 12; i++) begin
            if (i == 6) wr(OFS_GEN0_CONTROL, 32'h0000_0003);
            rd(OFS_GEN0_COUNT, rv);
            check(rv <= 32'h3, 32'h1);
        end
        wr(OFS_GEN0_CONTROL, 32'h0000_0000);
        wr(OFS_GEN0_IRQ_CLEAR, 32'h0000_003F);
        rchk(OFS_MOD_IRQ_RAW, 32'h0000_0000);
        check({gen_output_second, gen_output_first}, 32'h0);
        check(module_irq, 32'h0);
        // debug halt versus run
        debug_cmd <= 1'b1;
        wr(OFS_GEN0_CONTROL, 32'h0000_0001);
        repeat (12) @(posedge mclk);
        rd(OFS_GEN0_COUNT, rv);
        rd(OFS_GEN0_COUNT, rv2);
        check(rv | rv2, 32'h0);
        wr(OFS_GEN0_CONTROL, 32'h0000_0005);
        rd(OFS_GEN0_COUNT, rv);
        rd(OFS_GEN0_COUNT, rv2);
        check(rv != rv2, 32'h1);
        debug_cmd <= 1'b0;
        // load held back until sync request
        wr(OFS_GEN0_CONTROL, 32'h0000_0009);
        wr(OFS_GEN0_LOAD, 32'h0000_0007);
        big = 1'b0;
        for (i = 0; i < 16; i++) begin
            if (i == 8) wr(OFS_MASTER_CONTROL, 32'h0000_0001);
            rd(OFS_GEN0_COUNT, rv);
            if (i < 8) check(rv <= 32'h3, 32'h1);
            else if (rv > 32'h3) big = 1'b1;
        end
        check(big, 32'h1);
        rchk(OFS_MASTER_CONTROL, 32'h0000_0000);
        // output high time over four down-count periods of load 7
        m_ld = 7;
        m_dl = 0;
        wr(OFS_GEN0_CMP_A, 32'h0000_0003);
        wr(OFS_GEN0_CMP_B, 32'h0000_0005);
        hi_count();
        check(hi_q.pop_front(), m_hi(3));
        check(hi_q.pop_front(), m_hi(5));
        wr(OFS_GEN0_CONTROL, 32'h0000_0039);
        wr(OFS_GEN0_CMP_A, 32'h0000_0006);
        wr(OFS_GEN0_CMP_B, 32'h0000_0001);
        hi_count();
        check(hi_q.pop_front(), m_hi(3));
        check(hi_q.pop_front(), m_hi(5));
        wr(OFS_MASTER_CONTROL, 32'h0000_0001);
        hi_count();
        check(hi_q.pop_front(), m_hi(6));
        check(hi_q.pop_front(), m_hi(1));
        m_dl = 1;
        wr(OFS_GEN0_PAIR_DELAY, m_dl);
        wr(OFS_GEN0_PAIR_CTL, 32'h0000_0001);
        hi_count();
        check(hi_q.pop_front(), m_hi(6));
        check(hi_q.pop_front(), m_hi(m_ld + 1 - 6));
        wrap_up();
    end
endmodule : pwm_irq_and_gen_control_tb
`default_nettype wire
